// ==== logic/rwpm_ctrl.sv ====
// run, wait, low power and background mode controller
`timescale 1ns/1ps
module rwpm_ctrl #(
  parameter int ADDR_W = 16  // vector address width
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              por_reset_i,
  input  wire logic              force_reset_i,
  input  wire logic              debug_pin_i,
  input  wire logic              debug_pin_active_i,
  input  wire logic              pm_wr_i,
  input  wire logic              wr_lpr_i,
  input  wire logic              wr_wake_i,
  input  wire logic              wr_partial_powerdown_select_i,
  input  wire logic              low_voltage_detect_enable_i,
  input  wire logic              low_voltage_detect_stop_enable_i,
  input  wire logic              wait_exec_i,
  input  wire logic              background_instruction_instr_i,
  input  wire logic              bdc_bkpt_i,
  input  wire logic              dbg_bkpt_i,
  input  wire logic              irq_req_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [2:0]        cmd_code_i,
  output logic [2:0]             mode_o,
  output logic                   low_power_run_request_o,
  output logic                   low_power_run_status_o,
  output logic                   wake_to_full_regulation_o,
  output logic                   partial_powerdown_select_o,
  output logic                   lvd_force_off_o,
  output logic                   cpu_clk_en_o,
  output logic                   cpu_fetch_en_o,
  output logic                   cpu_mask_clear_o,
  output logic                   stack_start_o,
  output logic                   irq_service_o,
  output logic                   vector_fetch_o,
  output logic [ADDR_W-1:0]      vector_addr_o,
  output logic                   cmd_accept_o,
  output logic                   cmd_exec_o,
  output logic                   cmd_status_err_o
);
  // refuse an address bus too narrow for the vector
  if (ADDR_W < 16) begin : g_chk
    $error("ADDR_W must be at least 16");
  end

  typedef struct packed {
    rwpm_pkg::rwpm_mode_t mode;  // operating mode
    logic low_power_run_request;        // low power run request
    logic low_power_run_status;       // regulator in standby
    logic wake;       // wake to full regulation
    logic partial_powerdown_select;       // partial powerdown select
    logic wait_wake;  // wake bit caught at low power wait entry
    logic vec;        // vector fetch pulse
    logic mask_clr;   // interrupt mask clear pulse
    logic stack;      // stacking start pulse
    logic irq_svc;    // interrupt service pulse
  } rwpm_ctrl_st_t;

  rwpm_ctrl_st_t s;       // registered state
  rwpm_ctrl_st_t next_s;  // next state
  logic          pin_fall;   // debug pin falling edge
  logic          bdm_evt;    // any background entry cause
  logic          lpr_ok;     // request may be set now
  logic          pin_exit;   // active pin edge
  logic          lp_mode;    // regulator standby modes

  rwpm_dbg_if dbg ();

  assign dbg.mode      = s.mode;
  assign dbg.cmd_valid = cmd_valid_i;
  assign dbg.cmd_code  = cmd_code_i;

  // command admission by mode
  rwpm_cmd_gate u_gate (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .dbg       (dbg.gate)
  );

  // pin edge, only meaningful while debug is active
  rwpm_pin_edge u_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     (debug_pin_i),
    .fall_o    (pin_fall)
  );

  // mode sequencing and control bit updates
  always_comb begin
    next_s          = s;
    next_s.vec      = 1'b0;
    next_s.mask_clr = 1'b0;
    next_s.stack    = 1'b0;
    next_s.irq_svc  = 1'b0;
    bdm_evt  = background_instruction_instr_i || bdc_bkpt_i || dbg_bkpt_i ||
               dbg.background_instruction;
    pin_exit = pin_fall && debug_pin_active_i;
    lp_mode  = s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN ||
               s.mode == rwpm_pkg::RWPM_LOW_POWER_WAIT;
    // both detect enables set keeps the regulator up
    lpr_ok   = !s.partial_powerdown_select && !(low_voltage_detect_enable_i && low_voltage_detect_stop_enable_i) &&
               s.mode != rwpm_pkg::RWPM_BDM;
    // software write to the control bits
    if (pm_wr_i) begin
      next_s.wake = wr_wake_i;
      if (!wr_lpr_i) begin
        next_s.low_power_run_request = 1'b0;
      end else if (lpr_ok) begin
        next_s.low_power_run_request = 1'b1;
      end
      // request bit, existing or new, wins over powerdown
      if (!wr_partial_powerdown_select_i) begin
        next_s.partial_powerdown_select = 1'b0;
      end else if (!s.low_power_run_request && !next_s.low_power_run_request) begin
        next_s.partial_powerdown_select = 1'b1;
      end
    end
    case (s.mode)
      rwpm_pkg::RWPM_RESET_VEC: begin
        // straps sampled in the first clocked cycle
        next_s.vec = 1'b1;
        if ((por_reset_i || force_reset_i) && !debug_pin_i) begin
          next_s.mode = rwpm_pkg::RWPM_BDM;
        end else begin
          next_s.mode = rwpm_pkg::RWPM_RUN;
        end
      end
      rwpm_pkg::RWPM_RUN: begin
        if (bdm_evt) begin
          next_s.mode = rwpm_pkg::RWPM_BDM;
        end else if (irq_req_i) begin
          next_s.irq_svc = 1'b1;
        end else if (wait_exec_i) begin
          next_s.mode     = rwpm_pkg::RWPM_WAIT;
          next_s.mask_clr = 1'b1;
        end else if (next_s.low_power_run_request) begin
          next_s.mode = rwpm_pkg::RWPM_LOW_POWER_RUN;
        end
      end
      rwpm_pkg::RWPM_LOW_POWER_RUN: begin
        if (bdm_evt) begin
          // debugging needs full regulation
          next_s.mode = rwpm_pkg::RWPM_BDM;
          next_s.low_power_run_request  = 1'b0;
        end else if (pin_exit) begin
          next_s.mode = rwpm_pkg::RWPM_RUN;
          next_s.low_power_run_request  = 1'b0;
        end else if (irq_req_i) begin
          next_s.irq_svc = 1'b1;
          if (s.wake) begin
            next_s.mode = rwpm_pkg::RWPM_RUN;
            next_s.low_power_run_request  = 1'b0;
          end
        end else if (wait_exec_i) begin
          next_s.mode      = rwpm_pkg::RWPM_LOW_POWER_WAIT;
          next_s.wait_wake = s.wake;
          next_s.mask_clr  = 1'b1;
        end else if (!next_s.low_power_run_request) begin
          next_s.mode = rwpm_pkg::RWPM_RUN;
        end
      end
      rwpm_pkg::RWPM_WAIT: begin
        if (dbg.background_instruction) begin
          next_s.mode = rwpm_pkg::RWPM_BDM;
        end else if (irq_req_i) begin
          next_s.mode  = rwpm_pkg::RWPM_RUN;
          next_s.stack = 1'b1;
        end
      end
      rwpm_pkg::RWPM_LOW_POWER_WAIT: begin
        if (dbg.background_instruction) begin
          next_s.mode = rwpm_pkg::RWPM_BDM;
          next_s.low_power_run_request  = 1'b0;
        end else if (pin_exit) begin
          next_s.mode = rwpm_pkg::RWPM_RUN;
          next_s.low_power_run_request  = 1'b0;
        end else if (irq_req_i) begin
          next_s.stack = 1'b1;
          if (s.wait_wake) begin
            next_s.mode = rwpm_pkg::RWPM_RUN;
            next_s.low_power_run_request  = 1'b0;
          end else begin
            next_s.mode = rwpm_pkg::RWPM_LOW_POWER_RUN;
          end
        end
      end
      rwpm_pkg::RWPM_BDM: begin
        // request cannot be set here, so resume is normal run
        if (dbg.go) begin
          next_s.mode = rwpm_pkg::RWPM_RUN;
        end
      end
      default: begin
        next_s.mode = rwpm_pkg::RWPM_RESET_VEC;
      end
    endcase
    // status follows the regulator state of the next mode
    next_s.low_power_run_status = next_s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN ||
                  next_s.mode == rwpm_pkg::RWPM_LOW_POWER_WAIT;
  end

  // any reset drops low power and its bits
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs decoded from registered state only
  assign mode_o                     = s.mode;
  assign low_power_run_request_o    = s.low_power_run_request;
  assign low_power_run_status_o     = s.low_power_run_status;
  assign wake_to_full_regulation_o  = s.wake;
  assign partial_powerdown_select_o = s.partial_powerdown_select;
  assign lvd_force_off_o            = s.low_power_run_status;
  assign cpu_clk_en_o     = s.mode != rwpm_pkg::RWPM_WAIT &&
                            s.mode != rwpm_pkg::RWPM_LOW_POWER_WAIT;
  assign cpu_fetch_en_o   = s.mode == rwpm_pkg::RWPM_RUN ||
                            s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN;
  assign cpu_mask_clear_o = s.mask_clr;
  assign stack_start_o    = s.stack;
  assign irq_service_o    = s.irq_svc;
  assign vector_fetch_o   = s.vec;
  assign vector_addr_o    = ADDR_W'(rwpm_pkg::RESET_VEC_ADDR);
  assign cmd_accept_o     = dbg.acc;
  assign cmd_exec_o       = dbg.exec;
  assign cmd_status_err_o = dbg.err;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_boot_vector: assert property (s.mode == rwpm_pkg::RWPM_RESET_VEC &&
    debug_pin_i |=> vector_fetch_o && mode_o == rwpm_pkg::RWPM_RUN)
    else $error("no vector fetch into run");
  a_lvd_blocks_lp: assert property ($rose(low_power_run_request_o)
    |-> $past(!(low_voltage_detect_enable_i && low_voltage_detect_stop_enable_i)))
    else $error("low power set with both detect enables");
  a_status_full_reg: assert property (s.mode == rwpm_pkg::RWPM_RUN
    |-> !low_power_run_status_o && !lvd_force_off_o)
    else $error("status high in full regulation");
  a_low_power_run_irq_stay: assert property (s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN &&
    irq_req_i && !s.wake && !bdm_evt && !pin_exit && !pm_wr_i
    |=> s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN && irq_service_o)
    else $error("interrupt left low power run");
  a_wake_irq_full: assert property (s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN &&
    irq_req_i && s.wake && !bdm_evt && !pin_exit
    |=> !low_power_run_request_o && !low_power_run_status_o &&
        irq_service_o)
    else $error("wake interrupt kept standby");
  a_bdm_no_lpr: assert property (s.mode == rwpm_pkg::RWPM_BDM &&
    pm_wr_i && wr_lpr_i |=> !low_power_run_request_o)
    else $error("request set in background");
  a_pin_exit_run: assert property (lp_mode && pin_exit &&
    !bdm_evt && !dbg.background_instruction
    |=> mode_o == rwpm_pkg::RWPM_RUN && !low_power_run_request_o)
    else $error("pin edge did not exit low power");
  a_bdm_no_fetch: assert property (s.mode == rwpm_pkg::RWPM_BDM &&
    !dbg.go |=> !cpu_fetch_en_o [*1] ##0 !stack_start_o)
    else $error("fetch in background");
  a_wait_entry: assert property (s.mode == rwpm_pkg::RWPM_RUN &&
    wait_exec_i && !irq_req_i && !bdm_evt
    |=> cpu_mask_clear_o && !cpu_clk_en_o ##1 !cpu_mask_clear_o)
    else $error("wait entry wrong");
  a_wait_irq_stack: assert property (s.mode == rwpm_pkg::RWPM_WAIT &&
    irq_req_i && !dbg.background_instruction |=> stack_start_o && cpu_clk_en_o)
    else $error("wait interrupt did not stack");
  a_wait_background_instruction: assert property (s.mode == rwpm_pkg::RWPM_WAIT &&
    dbg.background_instruction |=> mode_o == rwpm_pkg::RWPM_BDM)
    else $error("enter command ignored in wait");
  a_low_power_wait_return: assert property (s.mode == rwpm_pkg::RWPM_LOW_POWER_WAIT &&
    irq_req_i && !s.wait_wake && !dbg.background_instruction && !pin_exit
    |=> mode_o == rwpm_pkg::RWPM_LOW_POWER_RUN &&
        low_power_run_request_o && low_power_run_status_o &&
        stack_start_o)
    else $error("low wait returned to wrong mode");
  a_low_power_wait_wake: assert property (s.mode == rwpm_pkg::RWPM_LOW_POWER_WAIT &&
    irq_req_i && s.wait_wake && !dbg.background_instruction && !pin_exit
    |=> mode_o == rwpm_pkg::RWPM_RUN && !low_power_run_request_o)
    else $error("low wait wake kept standby");
  a_partial_powerdown_select_excl: assert property (!(s.low_power_run_request && s.partial_powerdown_select))
    else $error("request and powerdown both set");

  c_low_power_run_entry: cover property (s.mode == rwpm_pkg::RWPM_RUN
    ##1 s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN);
  c_low_power_wait_round: cover property (s.mode == rwpm_pkg::RWPM_LOW_POWER_WAIT
    ##1 s.mode == rwpm_pkg::RWPM_LOW_POWER_RUN);
  c_wait_to_bdm: cover property (s.mode == rwpm_pkg::RWPM_WAIT
    ##1 s.mode == rwpm_pkg::RWPM_BDM);
  c_bdm_resume: cover property (s.mode == rwpm_pkg::RWPM_BDM
    ##1 s.mode == rwpm_pkg::RWPM_RUN);
endmodule : rwpm_ctrl

// ==== logic/rwpm_pkg.sv ====
// shared constants and types of the run/wait power mode control
package rwpm_pkg;
  // operating modes, binary codes written out
  typedef enum logic [2:0] {
    RWPM_RESET_VEC = 3'h0,  // first cycle after reset release
    RWPM_RUN       = 3'h1,  // normal run, full regulation
    RWPM_LOW_POWER_RUN     = 3'h2,  // low power run, regulator standby
    RWPM_WAIT      = 3'h3,  // processor clock stopped
    RWPM_LOW_POWER_WAIT    = 3'h4,  // wait with regulator standby
    RWPM_BDM       = 3'h5   // active background mode
  } rwpm_mode_t;

  // serial background command codes seen by the gate
  localparam logic [2:0] CMD_MEM      = 3'h0;
  localparam logic [2:0] CMD_MEM_STAT = 3'h1;
  localparam logic [2:0] CMD_BDC_REG  = 3'h2;
  localparam logic [2:0] CMD_BACKGROUND_INSTRUCTION     = 3'h3;
  localparam logic [2:0] CMD_CPU_REG  = 3'h4;
  localparam logic [2:0] CMD_TRACE    = 3'h5;
  localparam logic [2:0] CMD_GO       = 3'h6;

  // reset vector location (high byte first word)
  localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
  // reset value of the debug pin history (idle high)
  localparam logic        PIN_IDLE       = 1'h1;
endpackage : rwpm_pkg

// ==== logic/rwpm_dbg_if.sv ====
// carrier between the mode controller and the command gate
`timescale 1ns/1ps
interface rwpm_dbg_if;
  rwpm_pkg::rwpm_mode_t mode;       // current operating mode
  logic                 cmd_valid;  // command strobe
  logic [2:0]           cmd_code;   // command code
  logic                 acc;        // command accepted
  logic                 err;        // status error, no memory access
  logic                 exec;       // command carried out
  logic                 background_instruction;       // enter background request
  logic                 go;         // resume application request

  modport ctrl (output mode, cmd_valid, cmd_code,
                input  acc, err, exec, background_instruction, go);
  modport gate (input  mode, cmd_valid, cmd_code,
                output acc, err, exec, background_instruction, go);
endinterface : rwpm_dbg_if

// ==== logic/rwpm_cmd_gate.sv ====
// background command admission by operating mode
`timescale 1ns/1ps
module rwpm_cmd_gate (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  rwpm_dbg_if.gate  dbg
);
  typedef struct packed {
    logic acc;
    logic err;
    logic exec;
    logic background_instruction;
    logic go;
  } rwpm_gate_st_t;

  rwpm_gate_st_t s;       // registered verdict
  rwpm_gate_st_t next_s;  // next verdict
  logic          in_bdm;  // mode decodes
  logic          in_wait;
  logic          in_run;
  logic          status_cmd;

  // decide acceptance from mode and code
  always_comb begin
    in_bdm     = dbg.mode == rwpm_pkg::RWPM_BDM;
    in_wait    = dbg.mode == rwpm_pkg::RWPM_WAIT ||
                 dbg.mode == rwpm_pkg::RWPM_LOW_POWER_WAIT;
    in_run     = dbg.mode == rwpm_pkg::RWPM_RUN ||
                 dbg.mode == rwpm_pkg::RWPM_LOW_POWER_RUN;
    status_cmd = dbg.cmd_code == rwpm_pkg::CMD_MEM_STAT;
    next_s     = '0;
    if (dbg.cmd_valid) begin
      if (in_wait) begin
        // only status reads and enter-background get through
        next_s.acc = status_cmd ||
                     dbg.cmd_code == rwpm_pkg::CMD_BACKGROUND_INSTRUCTION;
        next_s.err = status_cmd;
      end else if (in_bdm) begin
        // everything up to resume is legal here
        next_s.acc = dbg.cmd_code <= rwpm_pkg::CMD_GO;
      end else if (in_run) begin
        // non-intrusive set only while the program runs
        next_s.acc = dbg.cmd_code <= rwpm_pkg::CMD_BACKGROUND_INSTRUCTION;
      end
      next_s.exec = next_s.acc && !next_s.err;
      next_s.background_instruction = next_s.acc && !in_bdm &&
                    dbg.cmd_code == rwpm_pkg::CMD_BACKGROUND_INSTRUCTION;
      next_s.go   = next_s.acc && in_bdm &&
                    dbg.cmd_code == rwpm_pkg::CMD_GO;
    end
  end

  // verdict register, one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dbg.acc  = s.acc;
  assign dbg.err  = s.err;
  assign dbg.exec = s.exec;
  assign dbg.background_instruction = s.background_instruction;
  assign dbg.go   = s.go;

  // status read in wait must flag the error and touch no memory
  a_wait_no_access: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    dbg.cmd_valid && in_wait && status_cmd |=> s.err && !s.exec)
    else $error("memory access during wait");
  a_active_cmd_bdm: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    dbg.cmd_valid && !in_bdm && dbg.cmd_code > rwpm_pkg::CMD_BACKGROUND_INSTRUCTION
    |=> !s.acc)
    else $error("active command outside background");
endmodule : rwpm_cmd_gate

// ==== logic/rwpm_pin_edge.sv ====
// falling edge detector on the debug pin
`timescale 1ns/1ps
module rwpm_pin_edge (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      fall_o
);
  typedef struct packed {
    logic prev;  // last pin level
    logic fall;  // registered edge pulse
  } rwpm_edge_st_t;

  rwpm_edge_st_t s;
  rwpm_edge_st_t next_s;

  // compare level with last sample
  always_comb begin
    next_s      = s;
    next_s.prev = pin_i;
    next_s.fall = s.prev && !pin_i;
  end

  // idle-high history so reset release with the pin high is no edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= {rwpm_pkg::PIN_IDLE, 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign fall_o = s.fall;
endmodule : rwpm_pin_edge

// ==== tb/rwpm_dbg_host.sv ====
// debug host model on the single-wire background pin
`timescale 1ns/1ps
module rwpm_dbg_host (
  input  wire logic clk_sys_i,
  output logic      debug_pin_o,
  output logic      cmd_valid_o,
  output logic [2:0] cmd_code_o
);
  // pin idles high on its pull-up, no command
  initial begin
    debug_pin_o = 1'h1;
    cmd_valid_o = 1'h0;
    cmd_code_o  = 3'h7;
  end
  // one command after gap idle cycles, prompt or slow
  task send(input logic [2:0] code, input int gap);
    repeat (gap) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    cmd_valid_o <= 1'h1;
    cmd_code_o  <= code;
    @(negedge clk_sys_i);
    cmd_valid_o <= 1'h0;
    // released code lines show junk, not the last value
    cmd_code_o  <= ~code;
  endtask : send
  // pin level, a fall when driven low
  task pin(input logic lvl);
    @(negedge clk_sys_i);
    debug_pin_o <= lvl;
  endtask : pin
endmodule : rwpm_dbg_host

// ==== tb/run_wait_power_mode_control_test.sv ====
// self-checking bench of the power mode controller
`timescale 1ns/1ps
module run_wait_power_mode_control_test;
  logic clk_sys, rst, por, frc, act, pm_wr, w_req, w_wake, w_ppd;
  logic lv_en, lv_sen, ev_wait, ev_bgi, brk_a, brk_b, irq;
  logic pin, cv, lp_req, lp_sts, wake, ppd, lvd_off, clk_en, fetch;
  logic mask, stack, isvc, vfetch, acc, exec, err;
  logic [2:0]  cc;
  logic [2:0]  mode;
  logic [15:0] vaddr;
  int          num_errors = 0;   // mismatches
  int          n_checks = 0;     // comparisons
  int          m_mode, m_req, m_wake, m_ppd; // reference state
  int          cq[$] = '{0, 1, 2, 4, 5, 6}; // all but enter
  int          cz[$] = '{8, 4, 2};          // other entry causes

  rwpm_ctrl rwpm_ctrl_inst (
    .clk_sys_i(clk_sys), .rst_i(rst), .por_reset_i(por),
    .force_reset_i(frc), .debug_pin_i(pin), .debug_pin_active_i(act),
    .pm_wr_i(pm_wr), .wr_lpr_i(w_req), .wr_wake_i(w_wake),
    .wr_partial_powerdown_select_i(w_ppd), .low_voltage_detect_enable_i(lv_en), .low_voltage_detect_stop_enable_i(lv_sen),
    .wait_exec_i(ev_wait), .background_instruction_instr_i(ev_bgi), .bdc_bkpt_i(brk_a),
    .dbg_bkpt_i(brk_b), .irq_req_i(irq), .cmd_valid_i(cv),
    .cmd_code_i(cc), .mode_o(mode), .low_power_run_request_o(lp_req),
    .low_power_run_status_o(lp_sts), .wake_to_full_regulation_o(wake),
    .partial_powerdown_select_o(ppd), .lvd_force_off_o(lvd_off),
    .cpu_clk_en_o(clk_en), .cpu_fetch_en_o(fetch),
    .cpu_mask_clear_o(mask), .stack_start_o(stack),
    .irq_service_o(isvc), .vector_fetch_o(vfetch),
    .vector_addr_o(vaddr), .cmd_accept_o(acc), .cmd_exec_o(exec),
    .cmd_status_err_o(err));

  rwpm_dbg_host rwpm_dbg_host_inst (
    .clk_sys_i(clk_sys), .debug_pin_o(pin), .cmd_valid_o(cv),
    .cmd_code_o(cc));

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  // verdict and end of run
  task stop_test();
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // one comparison, four-state exact
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // all standing outputs against the reference
  task chk_all();
    chk("mode", 16'(mode), 16'(m_mode));
    chk("req", 16'(lp_req), 16'(m_req));
    chk("sts", 16'(lp_sts), 16'(m_req));
    chk("lvd_off", 16'(lvd_off), 16'(m_req));
    chk("wake", 16'(wake), 16'(m_wake));
    chk("ppd", 16'(ppd), 16'(m_ppd));
    chk("clk_en", 16'(clk_en), 16'(!(m_mode inside {3, 4})));
    chk("fetch", 16'(fetch), 16'(m_mode inside {1, 2}));
  endtask : chk_all

  // reset with chosen cause flags and pin level
  task rst_seq(input logic p, input logic f, input logic lvl, input int md);
    rst = 1'h1;
    por = p;
    frc = f;
    rwpm_dbg_host_inst.pin(lvl);
    repeat (19) @(negedge clk_sys);
    rst = 1'h0;
    m_mode = md;
    m_req = 0;
    m_wake = 0;
    m_ppd = 0;
    @(negedge clk_sys);
    chk("vfetch", 16'(vfetch), 16'h0001);
    chk("vaddr", vaddr, 16'hfffe);
    chk_all();
    por = 1'h0;
    frc = 1'h0;
    rwpm_dbg_host_inst.pin(1'h1);
  endtask : rst_seq

  // control bit write, reference decides refusals
  task wr(input logic r, input logic w, input logic p);
    int nr;
    @(negedge clk_sys);
    {pm_wr, w_req, w_wake, w_ppd} = {1'h1, r, w, p};
    nr = (r && !m_req && (m_ppd || (lv_en && lv_sen) || m_mode == 5))
         ? 0 : int'(r);
    if (!(p && !m_ppd && (m_req || nr))) m_ppd = p;
    m_req = nr;
    m_wake = w;
    if (m_mode == 1 && nr) m_mode = 2;
    else if (m_mode == 2 && !nr) m_mode = 1;
    @(negedge clk_sys);
    pm_wr = 1'h0;
    chk_all();
  endtask : wr

  // one-cycle event pulse {wait, instr, brk_a, brk_b, irq}
  task ev(input logic [4:0] b);
    @(negedge clk_sys);
    {ev_wait, ev_bgi, brk_a, brk_b, irq} = b;
    @(negedge clk_sys);
    {ev_wait, ev_bgi, brk_a, brk_b, irq} = 5'h00;
  endtask : ev

  // background command, admission worked out from mode
  task cmd(input int c, input int g);
    int a, st;
    st = m_mode inside {3, 4};
    a = (m_mode == 5) || (m_mode inside {1, 2} && c < 4) ||
        (st && (c == 1 || c == 3));
    rwpm_dbg_host_inst.send(3'(c), g);
    chk("acc", 16'(acc), 16'(a));
    chk("err", 16'(err), 16'(a && st && c == 1));
    chk("exec", 16'(exec), 16'(a && !(st && c == 1)));
    if (a && c == 3) begin
      m_mode = 5;
      m_req = 0;
    end
    if (a && c == 6) m_mode = 1;
    @(negedge clk_sys);
    chk_all();
  endtask : cmd

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end

  // main sequence
  initial begin
    clk_sys = 1'h0;
    {act, pm_wr, w_req, w_wake, w_ppd, lv_en, lv_sen} = 7'h01 << 6;
    {ev_wait, ev_bgi, brk_a, brk_b, irq} = 5'h00;
    void'($urandom(32'h0000_6a8f));
    rst_seq(1'h1, 1'h0, 1'h1, 1);
    // random detect enables, both set must refuse
    for (int i = 0; i < 8; i++) begin
      {lv_en, lv_sen} = (i == 0) ? 2'h3 : 2'($urandom);
      wr(1'h1, 1'h0, 1'h0);
      wr(1'h0, 1'h0, 1'h0);
    end
    {lv_en, lv_sen} = 2'h0;
    // interrupts in low power run, wake clear then set
    // software is taken to have slowed the clocks beforehand
    wr(1'h1, 1'h0, 1'h0);
    ev(5'h01);
    chk("isvc", 16'(isvc), 16'h0001);
    chk_all();
    wr(1'h1, 1'h1, 1'h0);
    ev(5'h01);
    m_mode = 1;
    m_req = 0;
    chk("isvc", 16'(isvc), 16'h0001);
    chk_all();
    // wait: commands, interrupt, enter background
    wr(1'h0, 1'h0, 1'h0);
    ev(5'h10);
    m_mode = 3;
    chk("mask", 16'(mask), 16'h0001);
    chk_all();
    foreach (cq[i]) cmd(cq[i], i);
    ev(5'h01);
    m_mode = 1;
    chk("stack", 16'(stack), 16'h0001);
    chk_all();
    ev(5'h10);
    m_mode = 3;
    cmd(3, 2);
    // background: no low power entry, all commands but enter, go
    wr(1'h1, 1'h0, 1'h0);
    foreach (cq[i]) cmd(cq[i], 0);
    foreach (cq[i]) cmd(cq[i], 1);
    cmd(3, 0);
    cmd(6, 0);
    foreach (cz[i]) begin
      ev(5'(cz[i]));
      m_mode = 5;
      chk_all();
      cmd(6, 0);
    end
    // low power wait with wake clear, then set
    wr(1'h1, 1'h0, 1'h0);
    ev(5'h10);
    m_mode = 4;
    chk_all();
    ev(5'h01);
    m_mode = 2;
    chk("stack", 16'(stack), 16'h0001);
    chk_all();
    wr(1'h1, 1'h1, 1'h0);
    ev(5'h10);
    m_mode = 4;
    ev(5'h01);
    m_mode = 1;
    m_req = 0;
    chk_all();
    // pin fall leaves low power run and low power wait
    for (int k = 0; k < 2; k++) begin
      wr(1'h1, 1'h0, 1'h0);
      if (k == 1) begin
        ev(5'h10);
        m_mode = 4;
      end
      rwpm_dbg_host_inst.pin(1'h0);
      repeat (2) @(negedge clk_sys);
      m_mode = 1;
      m_req = 0;
      chk_all();
      rwpm_dbg_host_inst.pin(1'h1);
    end
    // inactive pin: a fall must not leave low power run
    act = 1'h0;
    wr(1'h1, 1'h0, 1'h0);
    rwpm_dbg_host_inst.pin(1'h0);
    repeat (2) @(negedge clk_sys);
    chk_all();
    rwpm_dbg_host_inst.pin(1'h1);
    act = 1'h1;
    wr(1'h0, 1'h0, 1'h0);
    // request and partial powerdown exclude each other
    wr(1'h0, 1'h0, 1'h1);
    wr(1'h1, 1'h0, 1'h1);
    wr(1'h0, 1'h0, 1'h0);
    wr(1'h1, 1'h0, 1'h0);
    wr(1'h1, 1'h0, 1'h1);
    // resets in low power run and low power wait
    rst_seq(1'h1, 1'h0, 1'h1, 1);
    wr(1'h1, 1'h0, 1'h0);
    ev(5'h10);
    rst_seq(1'h0, 1'h0, 1'h1, 1);
    // background entry from reset with pin low
    rst_seq(1'h1, 1'h0, 1'h0, 5);
    rst_seq(1'h0, 1'h1, 1'h0, 5);
    rst_seq(1'h0, 1'h0, 1'h0, 1);
    stop_test();
  end
endmodule : run_wait_power_mode_control_test
